/* design/irq_defs.svh */
// constants for the machine interrupt pending/enable block
// Overview of operation
// RULE_01: pending and enable bit i belong to cause i; 15:0 standard, 16+ platform.
// RULE_02: trap to machine needs privilege/global enable, pending and enable, and no delegation.
// RULE_03: trap condition re-evaluated boundedly after pending changes and right after CSR writes.
// RULE_04: machine-destined interrupts always beat lower-privilege-destined interrupts.
// RULE_05: writable pending bits are cleared by writing zero.
// RULE_06: read-only pending bits need another clearing path.
// RULE_07: enable bits writable when the cause can pend; others read zero.
// RULE_08: non-maskable interrupt never shows in the pending register.
// RULE_09: machine external pending is read-only, driven by the platform controller.
// RULE_10: machine timer pending is read-only, cleared by a timer compare write.
// RULE_11: machine software pending is read-only, driven by memory-mapped control writes.
// RULE_12: machine software pending and enable may read zero on single-hart systems.
// RULE_13: without supervisor mode, supervisor pending and enable bits read zero.
// RULE_14: supervisor external pending reads as software flag OR controller line.
// RULE_15: CSR write/set/clear of pending updates only the software flag.
// RULE_16: supervisor timer pending is writable by machine software.
// RULE_17: supervisor software pending is writable; controller may also set it.
// RULE_18: counter-overflow pending is read-write, set by overflow flags, else zero.
// RULE_19: priority: machine ext, soft, timer, supervisor ext, soft, timer, overflow.
// RULE_20: supervisor views show and mask only delegated bits; others read zero.
// RULE_21: delegated interrupts in supervisor or user mode go to the supervisor handler.
// RULE_22: bit positions: 1,3,5,7,9,11,13 for the seven standard causes.
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH
`define MXLEN          64
`define CAUSE_W        6
`define PLAT_LO        16
`define BIT_SSI        1
`define BIT_MSI        3
`define BIT_STI        5
`define BIT_MTI        7
`define BIT_SEI        9
`define BIT_MEI        11
`define BIT_LCOF       13
`define HAS_SMODE      1'b1
`define HAS_LCOF       1'b1
`define HAS_MSI        1'b1
`define MASK_ZERO      64'h0000_0000_0000_0000
`define MASK_SMODE     64'h0000_0000_0000_0222
`define MASK_LCOF      64'h0000_0000_0000_2000
`define MASK_MSI       64'h0000_0000_0000_0008
`define MASK_MACHINE   64'h0000_0000_0000_0880
`define MASK_PLATFORM  64'hffff_ffff_ffff_0000
`define MASK_SIP_WR    64'h0000_0000_0000_2002
`endif

/* design/irq_pkg.sv */
// types for the machine interrupt pending/enable block
package irq_pkg;
   typedef enum logic [1:0] {
      PRIV_USER       = 2'h0,
      PRIV_SUPERVISOR = 2'h1,
      PRIV_MACHINE    = 2'h3
   } priv_t;
   typedef enum logic [3:0] {
      SEL_MPENDING = 4'h1,
      SEL_MENABLE  = 4'h2,
      SEL_SPENDING = 4'h4,
      SEL_SENABLE  = 4'h8
   } csr_sel_t;
   typedef enum logic [1:0] {
      OP_READ  = 2'h0,
      OP_WRITE = 2'h1,
      OP_SET   = 2'h2,
      OP_CLEAR = 2'h3
   } csr_op_t;
endpackage : irq_pkg

/* design/machine_interrupt_pending_enable.sv */
// per-hart machine interrupt pending/enable registers, supervisor views and trap selection
`timescale 1ns/1ps
`include "irq_defs.svh"
module machine_interrupt_pending_enable (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    arst_n,
   // hart state
   input  wire irq_pkg::priv_t          current_priv,
   input  wire logic                    machine_global_enable,
   input  wire logic                    supervisor_global_enable,
   input  wire logic [`MXLEN-1:0]       delegation_mask,
   // interrupt sources, levels except the set pulse
   input  wire logic                    machine_external_interrupt,
   input  wire logic                    machine_timer_interrupt,
   input  wire logic                    machine_software_interrupt,
   input  wire logic                    supervisor_external_interrupt,
   input  wire logic                    supervisor_software_set,
   input  wire logic                    event_counter_overflow_flag,
   input  wire logic [`MXLEN-1:`PLAT_LO] platform_interrupt,
   // csr access
   input  wire logic                    csr_valid,
   input  wire irq_pkg::csr_sel_t       csr_sel,
   input  wire irq_pkg::csr_op_t        csr_op,
   input  wire logic [`MXLEN-1:0]       csr_wdata,
   output logic [`MXLEN-1:0]            csr_rdata,
   // trap requests
   output logic                         machine_trap_request,
   output logic [`CAUSE_W-1:0]          machine_trap_cause,
   output logic                         supervisor_trap_request,
   output logic [`CAUSE_W-1:0]          supervisor_trap_cause
);

   // read-modify-write of one csr, confined to the writable mask
   function automatic logic [`MXLEN-1:0] apply_op(
      input irq_pkg::csr_op_t  op,
      input logic [`MXLEN-1:0] base,
      input logic [`MXLEN-1:0] wdata,
      input logic [`MXLEN-1:0] mask);
      logic [`MXLEN-1:0] res;
      res = base;
      case (op)
         irq_pkg::OP_WRITE: res = wdata;
         irq_pkg::OP_SET:   res = base | wdata;
         irq_pkg::OP_CLEAR: res = base & ~wdata;
         default:           res = base;
      endcase
      return (base & ~mask) | (res & mask);
   endfunction : apply_op

   // cause number cut to the trap cause field
   function automatic logic [`CAUSE_W-1:0] cause_code(input int idx);
      logic [31:0] wide;
      wide = idx;
      return wide[`CAUSE_W-1:0];
   endfunction : cause_code

   // anything but a plain read modifies the selected register
   function automatic logic is_update(input irq_pkg::csr_op_t op);
      return op != irq_pkg::OP_READ;
   endfunction : is_update

   // fixed priority pick, {hit, cause}
   function automatic logic [`CAUSE_W:0] pick(input logic [`MXLEN-1:0] cand);
      logic [`CAUSE_W:0] r;
      r = '0;
      // platform causes first, lowest index wins among them
      for (int i = `MXLEN - 1; i >= `PLAT_LO; i--) begin
         if (cand[i]) begin
            r = {1'b1, cause_code(i)};
         end
      end
      if (r[`CAUSE_W] == 1'b0) begin
         if (cand[`BIT_MEI]) begin // see RULE_19
            r = {1'b1, cause_code(`BIT_MEI)};
         end else if (cand[`BIT_MSI]) begin
            r = {1'b1, cause_code(`BIT_MSI)};
         end else if (cand[`BIT_MTI]) begin
            r = {1'b1, cause_code(`BIT_MTI)};
         end else if (cand[`BIT_SEI]) begin
            r = {1'b1, cause_code(`BIT_SEI)};
         end else if (cand[`BIT_SSI]) begin
            r = {1'b1, cause_code(`BIT_SSI)};
         end else if (cand[`BIT_STI]) begin
            r = {1'b1, cause_code(`BIT_STI)};
         end else if (cand[`BIT_LCOF]) begin
            r = {1'b1, cause_code(`BIT_LCOF)};
         end
      end
      return r;
   endfunction : pick

   logic [`MXLEN-1:0]   soft_pending;
   logic [`MXLEN-1:0]   enable;
   logic                overflow_seen;
   logic [`MXLEN-1:0]   next_soft_pending;
   logic [`MXLEN-1:0]   next_enable;
   logic                next_overflow_seen;
   logic [`MXLEN-1:0]   next_csr_rdata;
   logic                next_machine_trap_request;
   logic [`CAUSE_W-1:0] next_machine_trap_cause;
   logic                next_supervisor_trap_request;
   logic [`CAUSE_W-1:0] next_supervisor_trap_cause;

   logic [`MXLEN-1:0]   soft_mask;
   logic [`MXLEN-1:0]   enable_mask;
   logic [`MXLEN-1:0]   deleg;
   logic [`MXLEN-1:0]   pending_view;
   wire  [`MXLEN-1:0]   machine_cand;
   wire  [`MXLEN-1:0]   super_cand;
   logic                machine_ok;
   logic                super_ok;
   logic [`CAUSE_W:0]   machine_pick;
   logic [`CAUSE_W:0]   super_pick;

   // per-cause arming: pending and enabled, split by delegation
   for (genvar b = 0; b < `MXLEN; b++) begin : g_arm
      assign machine_cand[b] = pending_view[b] & enable[b] & ~deleg[b]; // see RULE_02
      assign super_cand[b]   = pending_view[b] & enable[b] & deleg[b]; // see RULE_21
   end

   // implemented-bit masks
   always_comb begin
      // software-held pending bits: supervisor ext flag, timer, software, overflow
      soft_mask = `MASK_ZERO;
      if (`HAS_SMODE) begin
         soft_mask = soft_mask | `MASK_SMODE; // see RULE_13
      end
      if (`HAS_LCOF) begin
         soft_mask = soft_mask | `MASK_LCOF; // see RULE_18
      end
      // every cause that can pend gets a writable enable
      enable_mask = soft_mask | `MASK_MACHINE | `MASK_PLATFORM; // see RULE_07
      if (`HAS_MSI) begin
         enable_mask = enable_mask | `MASK_MSI; // see RULE_12
      end
      // delegation only exists with supervisor mode
      deleg = `HAS_SMODE ? delegation_mask : `MASK_ZERO;
   end

   // effective pending word; no bit carries the non-maskable interrupt
   always_comb begin
      pending_view = soft_pending & soft_mask; // see RULE_08
      pending_view[`MXLEN-1:`PLAT_LO] = platform_interrupt; // see RULE_01
      pending_view[`BIT_MEI] = machine_external_interrupt; // see RULE_09, RULE_22
      pending_view[`BIT_MTI] = machine_timer_interrupt; // see RULE_06, RULE_10
      pending_view[`BIT_MSI] = machine_software_interrupt & `HAS_MSI; // see RULE_11
      // controller line only affects what is read and what traps
      pending_view[`BIT_SEI] = (soft_pending[`BIT_SEI] | supervisor_external_interrupt)
                               & `HAS_SMODE; // see RULE_14
   end

   // pending state: csr updates first, then hardware sets
   always_comb begin
      next_soft_pending  = soft_pending;
      next_overflow_seen = event_counter_overflow_flag;
      if (csr_valid && is_update(csr_op)) begin
         case (csr_sel)
            irq_pkg::SEL_MPENDING: begin
               // base is the stored flag, never the controller line
               next_soft_pending = apply_op(csr_op, soft_pending, csr_wdata,
                                            soft_mask); // see RULE_05, RULE_15, RULE_16, RULE_17
            end
            irq_pkg::SEL_SPENDING: begin
               next_soft_pending = apply_op(csr_op, soft_pending, csr_wdata,
                                            soft_mask & deleg & `MASK_SIP_WR); // see RULE_20
            end
            default: begin
               next_soft_pending = soft_pending;
            end
         endcase
      end
      // hardware sets land after the write so a same-cycle clear cannot lose them
      if (`HAS_SMODE && supervisor_software_set) begin
         next_soft_pending[`BIT_SSI] = 1'b1; // see RULE_17
      end
      if (`HAS_LCOF && event_counter_overflow_flag && !overflow_seen) begin
         next_soft_pending[`BIT_LCOF] = 1'b1; // see RULE_18
      end
      next_soft_pending = next_soft_pending & soft_mask;
   end

   // enable state
   always_comb begin
      next_enable = enable;
      if (csr_valid && is_update(csr_op)) begin
         case (csr_sel)
            irq_pkg::SEL_MENABLE: begin
               next_enable = apply_op(csr_op, enable, csr_wdata, enable_mask); // see RULE_07
            end
            irq_pkg::SEL_SENABLE: begin
               next_enable = apply_op(csr_op, enable, csr_wdata, enable_mask & deleg); // see RULE_20
            end
            default: begin
               next_enable = enable;
            end
         endcase
      end
      next_enable = next_enable & enable_mask;
   end

   // read path: pre-write value of the selected register, zero when idle
   always_comb begin
      next_csr_rdata = `MASK_ZERO;
      if (csr_valid) begin
         case (csr_sel)
            irq_pkg::SEL_MPENDING: begin
               next_csr_rdata = pending_view; // see RULE_14
            end
            irq_pkg::SEL_MENABLE: begin
               next_csr_rdata = enable & enable_mask; // see RULE_07
            end
            irq_pkg::SEL_SPENDING: begin
               next_csr_rdata = pending_view & deleg; // see RULE_20
            end
            irq_pkg::SEL_SENABLE: begin
               next_csr_rdata = enable & enable_mask & deleg; // see RULE_20
            end
            default: begin
               next_csr_rdata = `MASK_ZERO;
            end
         endcase
      end
   end

   // trap selection, recomputed every cycle from current state
   always_comb begin
      case (current_priv)
         irq_pkg::PRIV_MACHINE: begin
            machine_ok = machine_global_enable; // see RULE_02
            super_ok   = 1'b0; // see RULE_21
         end
         irq_pkg::PRIV_SUPERVISOR: begin
            machine_ok = 1'b1;
            super_ok   = supervisor_global_enable; // see RULE_21
         end
         irq_pkg::PRIV_USER: begin
            machine_ok = 1'b1;
            super_ok   = 1'b1;
         end
         default: begin
            // unused encoding: only the machine level may trap
            machine_ok = 1'b1;
            super_ok   = 1'b0;
         end
      endcase
      machine_pick = pick(machine_cand);
      super_pick   = pick(super_cand);
      // one-cycle latency after a pending or enable change, two cycles after a csr write
      next_machine_trap_request = 1'b0;
      next_machine_trap_cause   = '0;
      if (machine_ok && machine_pick[`CAUSE_W]) begin
         next_machine_trap_request = 1'b1; // see RULE_03
         next_machine_trap_cause   = machine_pick[`CAUSE_W-1:0];
      end
      // a machine request suppresses any supervisor one
      next_supervisor_trap_request = 1'b0;
      next_supervisor_trap_cause   = '0;
      if (super_ok && super_pick[`CAUSE_W] && !next_machine_trap_request) begin // see RULE_04
         next_supervisor_trap_request = 1'b1;
         next_supervisor_trap_cause   = super_pick[`CAUSE_W-1:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_pending  <= `MASK_ZERO;
         overflow_seen <= 1'b0;
      end else begin
         soft_pending  <= next_soft_pending;
         overflow_seen <= next_overflow_seen;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         enable <= `MASK_ZERO;
      end else begin
         enable <= next_enable;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         csr_rdata <= `MASK_ZERO;
      end else begin
         csr_rdata <= next_csr_rdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         machine_trap_request    <= 1'b0;
         machine_trap_cause      <= '0;
         supervisor_trap_request <= 1'b0;
         supervisor_trap_cause   <= '0;
      end else begin
         machine_trap_request    <= next_machine_trap_request;
         machine_trap_cause      <= next_machine_trap_cause;
         supervisor_trap_request <= next_supervisor_trap_request;
         supervisor_trap_cause   <= next_supervisor_trap_cause;
      end
   end

endmodule : machine_interrupt_pending_enable

/* verif/irq_sources.sv */
// behavioural platform side: interrupt controller, timer and software-interrupt register
`timescale 1ns/1ps
module irq_sources (
   // clock, reset and bench command bits
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [7:0] cmd,
   // lines toward the hart
   output logic            machine_external_interrupt,
   output logic            machine_timer_interrupt,
   output logic            machine_software_interrupt,
   output logic            supervisor_external_interrupt,
   output logic            supervisor_software_set,
   output logic            event_counter_overflow_flag
);
   // cmd: 0 ext, 1 timer fire, 2 compare write, 3 sw write, 4 sw data, 5 sup ext, 6 sup sw, 7 overflow
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {machine_external_interrupt, machine_timer_interrupt, machine_software_interrupt} <= 3'h0;
         {supervisor_external_interrupt, supervisor_software_set, event_counter_overflow_flag} <= 3'h0;
      end else begin
         machine_external_interrupt    <= cmd[0];
         // timer stays due until its compare register is written
         machine_timer_interrupt       <= !cmd[2] && (machine_timer_interrupt || cmd[1]);
         machine_software_interrupt    <= cmd[3] ? cmd[4] : machine_software_interrupt;
         supervisor_external_interrupt <= cmd[5];
         supervisor_software_set       <= cmd[6];
         event_counter_overflow_flag   <= cmd[7];
      end
   end
endmodule : irq_sources

/* verif/irq_gate_asserts.sv */
// checker for the pending/enable block, bound to its ports
`timescale 1ns/1ps
module irq_gate_asserts (
   // clock and reset
   input wire logic           clk,
   input wire logic           arst_n,
   // hart state and sources
   input wire irq_pkg::priv_t current_priv,
   input wire logic           machine_global_enable,
   input wire logic [63:0]    delegation_mask,
   input wire logic           machine_external_interrupt,
   input wire logic           machine_timer_interrupt,
   input wire logic           machine_software_interrupt,
   // csr port
   input wire logic           csr_valid,
   input wire irq_pkg::csr_sel_t csr_sel,
   input wire irq_pkg::csr_op_t  csr_op,
   input wire logic [63:0]    csr_wdata,
   input wire logic [63:0]    csr_rdata,
   // trap outputs
   input wire logic           machine_trap_request,
   input wire logic [5:0]     machine_trap_cause,
   input wire logic           supervisor_trap_request
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_en_wr;
      csr_valid && csr_sel == irq_pkg::SEL_MENABLE && csr_op == irq_pkg::OP_WRITE;
   endsequence
   sequence s_en_rd;
      csr_valid && csr_sel == irq_pkg::SEL_MENABLE && csr_op == irq_pkg::OP_READ;
   endsequence
   a_en_readback: assert property (s_en_wr ##1 s_en_rd |=>
      csr_rdata == ($past(csr_wdata, 2) & 64'hffff_ffff_ffff_2aaa)) else $error("enable readback wrong");
   a_machine_first: assert property (machine_trap_request |-> !supervisor_trap_request)
      else $error("supervisor request beside machine request");
   a_priv_gate: assert property (current_priv == irq_pkg::PRIV_MACHINE && !machine_global_enable
      |=> !machine_trap_request) else $error("machine trap while globally disabled");
   a_deleg_gate: assert property (machine_trap_request |->
      (($past(delegation_mask) >> machine_trap_cause) & 64'h1) == 64'h0) else $error("delegated cause to machine");
   a_ext_source: assert property (machine_trap_request && machine_trap_cause == 6'h0b
      |-> $past(machine_external_interrupt)) else $error("external cause without line");
   a_timer_source: assert property (machine_trap_request && machine_trap_cause == 6'h07
      |-> $past(machine_timer_interrupt)) else $error("timer cause without line");
   a_soft_source: assert property (machine_trap_request && machine_trap_cause == 6'h03
      |-> $past(machine_software_interrupt)) else $error("software cause without line");
   a_sup_mmode: assert property (current_priv == irq_pkg::PRIV_MACHINE |=> !supervisor_trap_request)
      else $error("supervisor trap in machine mode");
endmodule : irq_gate_asserts
bind machine_interrupt_pending_enable irq_gate_asserts u_irq_gate_asserts (.*);

/* verif/tb_machine_interrupt_pending_enable.sv */
// self-checking bench: csr access, priority, gating and delegation
`timescale 1ns/1ps
module tb_machine_interrupt_pending_enable;
   localparam logic [63:0] EN_MASK = 64'hffff_ffff_ffff_2aaa;
   logic clk = 1'b0, arst_n = 1'b0, csr_valid = 1'b0, taken = 1'b0;
   logic machine_global_enable = 1'b0, supervisor_global_enable = 1'b0;
   irq_pkg::priv_t current_priv = irq_pkg::PRIV_USER;
   irq_pkg::csr_sel_t csr_sel = irq_pkg::SEL_MPENDING;
   irq_pkg::csr_op_t csr_op = irq_pkg::OP_READ;
   logic [63:0] delegation_mask = 64'h0, csr_wdata = 64'h0, csr_rdata, rnd, pend = 64'h2222;
   logic [63:16] platform_interrupt = 48'h0;
   logic [7:0] cmd = 8'h00;
   logic machine_trap_request, supervisor_trap_request;
   logic [5:0] machine_trap_cause, supervisor_trap_cause;
   logic machine_external_interrupt, machine_timer_interrupt, machine_software_interrupt;
   logic supervisor_external_interrupt, supervisor_software_set, event_counter_overflow_flag;
   logic [63:0] exp_q[$];
   logic [5:0] cause_t[7] = '{6'h0b, 6'h03, 6'h07, 6'h09, 6'h01, 6'h05, 6'h0d};
   logic [7:0] cmd_t[7] = '{8'h1b, 8'h1a, 8'h08, 8'h04, 8'h04, 8'h04, 8'h04};
   logic [63:0] mask_t[7] = '{64'h0, 64'h0, 64'h0, 64'h200, 64'h2, 64'h20, 64'h2000};
   int error_cnt = 0, comparisons = 0, cycles = 0, seed = 87, pidx;
   machine_interrupt_pending_enable u_machine_interrupt_pending_enable (.*);
   irq_sources u_irq_sources (.*);
   initial forever #2.5 clk = ~clk;
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   // every access notes the old value it must return; valid is held for back-to-back use
   task automatic csr(input logic [3:0] s, input logic [1:0] o, input logic [63:0] w, input logic [63:0] e);
      csr_valid = 1'b1;
      csr_sel = irq_pkg::csr_sel_t'(s);
      csr_op = irq_pkg::csr_op_t'(o);
      csr_wdata = w;
      exp_q.push_back(e);
      @(negedge clk);
   endtask : csr
   // partner edge, then one or two design edges, before the trap outputs settle
   task automatic trap(input logic [7:0] c, input logic [6:0] m, input logic [6:0] s);
      cmd = c;
      repeat (3) @(negedge clk);
      check("machine trap", {57'h0, machine_trap_request, machine_trap_cause}, {57'h0, m});
      check("supervisor trap", {57'h0, supervisor_trap_request, supervisor_trap_cause}, {57'h0, s});
   endtask : trap
   always @(posedge clk) taken <= csr_valid;
   always @(negedge clk) begin
      cycles++;
      if (taken) check("csr_rdata", csr_rdata, exp_q.pop_front());
      if (cycles > 1500) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      rnd = {$random(seed), $random(seed)};
      csr(4'h2, 2'h0, 64'h0, 64'h0);
      csr(4'h2, 2'h1, rnd, 64'h0);
      csr(4'h2, 2'h1, ~64'h0, rnd & EN_MASK);
      csr(4'h2, 2'h0, 64'h0, EN_MASK);
      csr(4'h1, 2'h2, 64'h2222, 64'h0);
      csr_valid = 1'b0;
      pidx = 16 + ($unsigned($random(seed)) % 48);
      platform_interrupt[pidx] = 1'b1;
      trap(8'h1b, {1'b1, pidx[5:0]}, 7'h00);
      csr(4'h1, 2'h0, 64'h0, (64'h1 << pidx) | 64'h2aaa);
      csr(4'h1, 2'h1, 64'h0, (64'h1 << pidx) | 64'h2aaa);
      csr(4'h1, 2'h0, 64'h0, (64'h1 << pidx) | 64'h0888);
      csr(4'h1, 2'h2, 64'h2222, (64'h1 << pidx) | 64'h0888);
      csr_valid = 1'b0;
      platform_interrupt = 48'h0;
      for (int i = 0; i < 7; i++) begin
         trap(cmd_t[i], {1'b1, cause_t[i]}, 7'h00);
         if (mask_t[i] != 64'h0) begin
            csr(4'h1, 2'h3, mask_t[i], pend);
            pend = pend & ~mask_t[i];
            csr_valid = 1'b0;
         end
      end
      trap(8'h00, 7'h00, 7'h00);
      trap(8'h40, {1'b1, 6'h01}, 7'h00);
      trap(8'h80, {1'b1, 6'h01}, 7'h00);
      csr(4'h1, 2'h3, 64'h2, 64'h2002);
      csr_valid = 1'b0;
      trap(8'h80, {1'b1, 6'h0d}, 7'h00);
      csr(4'h1, 2'h3, 64'h2000, 64'h2000);
      csr_valid = 1'b0;
      trap(8'h80, 7'h00, 7'h00);
      trap(8'h20, {1'b1, 6'h09}, 7'h00);
      csr(4'h1, 2'h2, 64'h0, 64'h200);
      csr_valid = 1'b0;
      trap(8'h00, 7'h00, 7'h00);
      current_priv = irq_pkg::PRIV_MACHINE;
      trap(8'h01, 7'h00, 7'h00);
      machine_global_enable = 1'b1;
      trap(8'h01, {1'b1, 6'h0b}, 7'h00);
      delegation_mask = 64'h800;
      trap(8'h01, 7'h00, 7'h00);
      delegation_mask = 64'h200;
      current_priv = irq_pkg::PRIV_USER;
      trap(8'h20, 7'h00, {1'b1, 6'h09});
      current_priv = irq_pkg::PRIV_SUPERVISOR;
      trap(8'h20, 7'h00, 7'h00);
      supervisor_global_enable = 1'b1;
      trap(8'h20, 7'h00, {1'b1, 6'h09});
      trap(8'h21, {1'b1, 6'h0b}, 7'h00);
      csr(4'h4, 2'h0, 64'h0, 64'h200);
      csr(4'h8, 2'h0, 64'h0, 64'h200);
      csr_valid = 1'b0;
      repeat (3) @(negedge clk);
      test_done();
   end
endmodule : tb_machine_interrupt_pending_enable
